// ==== nvs_pkg.sv ====
// Constants, types and timing for the store/recall sequencer.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
// Functional notes
// - A power-loss or pin-requested store is skipped when no SRAM write happened since the last store or recall.
// - Once a pin or power-loss store is triggered, SRAM writes stay enabled for at most 25 ns; the code keeps them enabled for one 100 ns cycle.
// - Reads and writes are ignored during store, during recall and while the supply is below trip; a store ends within 8 ms.
// - The power-up recall ends within 20 ms, or 40 ms on the low-voltage variant, counted from the supply rising above trip.
// - After the store/busy pin returns high the device is ready for access within 5 us; after a store or recall the code opens access 5.5 us later.
// - The device drives the store/busy pin high for no more than 500 ns before releasing it.
// - After a sleep command the low-power state is reached within 8 ms.
// - Wake from sleep ends within 20 ms, or 40 ms on the low-voltage variant.
// - After a bus stop condition the device enters standby within 100 us.
// - A software command sequence is acted on within 500 us.
// - Bus data access is locked until a software store or recall ends; a recall ends within 600 us.
// - SRAM access stays disabled while an outside agent holds the store/busy pin low.
package nvs_pkg;

  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CNT_W = 20;
  localparam int STORE_MAX_MS = 8;
  localparam int PU_MAX_MS = 20;
  localparam int PU_LV_MAX_MS = 40;
  localparam int RECALL_MAX_US = 600;
  localparam int SLEEP_MAX_MS = 8;
  localparam int DELAY_MAX_NS = 25;
  localparam int REL_MAX_US = 5;
  localparam int HIDRV_MAX_NS = 500;
  // Supply sense passes two flops, then one edge to leave OFF
  localparam int SYNC_CYC = 3;

  // Longest times round down, never below one cycle
  localparam int STORE_CYC = STORE_MAX_MS * (CLK_HZ / 1000);
  localparam int PU_CYC = PU_MAX_MS * (CLK_HZ / 1000);
  localparam int PU_LV_CYC = PU_LV_MAX_MS * (CLK_HZ / 1000);
  localparam int RECALL_CYC = RECALL_MAX_US * (CLK_HZ / 1_000_000);
  localparam int SLEEP_CYC = SLEEP_MAX_MS * (CLK_HZ / 1000);
  localparam int DELAY_RAW = DELAY_MAX_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int DELAY_CYC = (DELAY_RAW < 1) ? 1 : DELAY_RAW;
  localparam int REL_CYC = REL_MAX_US * (CLK_HZ / 1_000_000);
  localparam int HIDRV_CYC = HIDRV_MAX_NS * (CLK_HZ / 1_000_000) / 1000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NVS_OFF      = 4'h0,
    NVS_PWRUP    = 4'h1,
    NVS_HIGHDRV  = 4'h3,
    NVS_RELEASE  = 4'h2,
    NVS_READY    = 4'h6,
    NVS_GRACE    = 4'h7,
    NVS_STORE    = 4'h5,
    NVS_RECALL   = 4'h4,
    NVS_SLEEP_IN = 4'hC,
    NVS_SLEEP    = 4'hD,
    NVS_WAKE     = 4'hF
  } nvs_st_t;

  typedef struct packed {
    logic load;
    logic [CNT_W-1:0] val;
  } nvs_tmr_req_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } nvs_tmr_t;

  localparam nvs_tmr_t NVS_TMR_RST = '{cnt: '0, done: 1'b0};

  typedef struct packed {
    nvs_st_t st;
    logic vcc_m;
    logic vcc_s;
    logic pin_m;
    logic pin_s;
    logic dirty;
    logic auto_st;
    logic standby;
    logic access;
    logic wr_en;
    logic pin_o;
    logic pin_oe;
    logic sleep;
  } nvs_state_t;

  localparam nvs_state_t NVS_STATE_RST = '{
    st: NVS_OFF, vcc_m: 1'b0, vcc_s: 1'b0, pin_m: 1'b1, pin_s: 1'b1,
    dirty: 1'b0, auto_st: 1'b0, standby: 1'b0, access: 1'b0,
    wr_en: 1'b0, pin_o: 1'b0, pin_oe: 1'b0, sleep: 1'b0};

endpackage

// ==== nvs_timer.sv ====
// Loadable down-counter that pulses done when a loaded span expires.
// Assumes the same clock, reset and clock enable as the sequencer.
`timescale 1ns/10ps
module nvs_timer
  import nvs_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire nvs_pkg::nvs_tmr_req_t req_in,
  output logic done_out
);
  import nvs_pkg::*;

  nvs_tmr_t s_q;
  nvs_tmr_t s_d;

  // Done shows in the Nth cycle after a load of N, so the owner's
  // state lasts exactly N cycles; a load of 1 flags done at once
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (req_in.load)
    begin
      s_d.cnt = req_in.val;
      s_d.done = (req_in.val == CNT_W'(1));
    end
    else if (s_q.cnt != '0)
    begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
      s_d.done = (s_q.cnt == CNT_W'(2));
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      s_q <= NVS_TMR_RST;
    else if (ce_in)
      s_q <= s_d;
  end

  assign done_out = s_q.done;

endmodule

// ==== nvs_seq.sv ====
// Store/recall sequencer of a nonvolatile SRAM.
// Assumes the supply-ok and store/busy pins are asynchronous, while the
// write strobe and command pulses come from logic on clk_in.
`timescale 1ns/10ps
module nvs_seq
  import nvs_pkg::*;
#(
  parameter bit LOW_VCC_VARIANT = 1'b0,
  parameter int STORE_CYCLES = STORE_CYC,
  parameter int PU_CYCLES = PU_CYC,
  parameter int PU_LV_CYCLES = PU_LV_CYC,
  parameter int RECALL_CYCLES = RECALL_CYC,
  parameter int SLEEP_CYCLES = SLEEP_CYC
)
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic vcc_ok_in,
  input wire logic store_busy_pin_n_in,
  input wire logic sram_write_in,
  input wire logic sw_store_in,
  input wire logic sw_recall_in,
  input wire logic sleep_cmd_in,
  input wire logic wake_in,
  input wire logic bus_stop_in,
  input wire logic bus_start_in,
  output logic store_busy_pin_n_out,
  output logic store_busy_pin_n_oe_out,
  output logic access_en_out,
  output logic write_en_out,
  output logic dirty_out,
  output logic standby_out,
  output logic sleep_out
);
  import nvs_pkg::*;

  // ----------------------------------------------------------------
  // State and timer
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] ST_LD = CNT_W'(STORE_CYCLES);
  localparam logic [CNT_W-1:0] RC_LD = CNT_W'(RECALL_CYCLES);
  localparam logic [CNT_W-1:0] SL_LD = CNT_W'(SLEEP_CYCLES);
  localparam logic [CNT_W-1:0] PU_LD =
    LOW_VCC_VARIANT ? CNT_W'(PU_LV_CYCLES) : CNT_W'(PU_CYCLES);
  // Recall span counts from the supply edge, so the sense flops and
  // the exit from OFF are taken off the timer
  localparam logic [CNT_W-1:0] PR_LD = PU_LD - CNT_W'(SYNC_CYC);
  localparam logic [CNT_W-1:0] HH_LD = CNT_W'(HIDRV_CYC);
  localparam logic [CNT_W-1:0] LZ_LD = CNT_W'(REL_CYC);
  localparam logic [CNT_W-1:0] DL_LD = CNT_W'(DELAY_CYC);

  nvs_state_t s_q;
  nvs_state_t s_d;
  nvs_tmr_req_t tmr_req;
  logic tmr_done;
  logic wr_ok;
  logic clr;

  nvs_timer u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .req_in(tmr_req),
    .done_out(tmr_done)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    tmr_req = '{load: 1'b0, val: '0};
    clr = 1'b0;
    s_d.vcc_m = vcc_ok_in;
    s_d.vcc_s = s_q.vcc_m;
    s_d.pin_m = store_busy_pin_n_in;
    s_d.pin_s = s_q.pin_m;
    wr_ok = sram_write_in && s_q.wr_en;
    unique case (s_q.st)
      NVS_OFF:
      begin
        if (s_q.vcc_s)
        begin
          s_d.st = NVS_PWRUP;
          tmr_req = '{load: 1'b1, val: PR_LD};
        end
      end
      NVS_PWRUP, NVS_RECALL:
      begin
        if (!s_q.vcc_s)
          s_d.st = NVS_OFF;
        else if (tmr_done)
        begin
          clr = 1'b1;
          s_d.st = NVS_HIGHDRV;
          tmr_req = '{load: 1'b1, val: HH_LD};
        end
      end
      NVS_READY:
      begin
        if (bus_stop_in)
          s_d.standby = 1'b1;
        else if (bus_start_in)
          s_d.standby = 1'b0;
        if (!s_q.vcc_s)
        begin
          s_d.st = s_q.dirty ? NVS_GRACE : NVS_OFF;
          s_d.auto_st = 1'b1;
          tmr_req = '{load: 1'b1, val: DL_LD};
        end
        else if (!s_q.pin_s)
        begin
          if (s_q.dirty)
          begin
            s_d.st = NVS_GRACE;
            s_d.auto_st = 1'b0;
            tmr_req = '{load: 1'b1, val: DL_LD};
          end
        end
        else if (sw_store_in)
        begin
          s_d.st = NVS_STORE;
          s_d.auto_st = 1'b0;
          tmr_req = '{load: 1'b1, val: ST_LD};
        end
        else if (sw_recall_in)
        begin
          s_d.st = NVS_RECALL;
          tmr_req = '{load: 1'b1, val: RC_LD};
        end
        else if (sleep_cmd_in)
        begin
          s_d.st = NVS_SLEEP_IN;
          tmr_req = '{load: 1'b1, val: SL_LD};
        end
      end
      NVS_GRACE:
      begin
        if (tmr_done)
        begin
          s_d.st = NVS_STORE;
          tmr_req = '{load: 1'b1, val: ST_LD};
        end
      end
      NVS_STORE:
      begin
        if (tmr_done)
        begin
          clr = 1'b1;
          if (s_q.auto_st || !s_q.vcc_s)
            s_d.st = NVS_OFF;
          else
          begin
            s_d.st = NVS_HIGHDRV;
            tmr_req = '{load: 1'b1, val: HH_LD};
          end
        end
      end
      NVS_HIGHDRV:
      begin
        if (tmr_done)
        begin
          s_d.st = NVS_RELEASE;
          tmr_req = '{load: 1'b1, val: LZ_LD};
        end
      end
      NVS_RELEASE:
      begin
        if (tmr_done)
          s_d.st = NVS_READY;
      end
      NVS_SLEEP_IN:
      begin
        if (tmr_done)
          s_d.st = NVS_SLEEP;
      end
      NVS_SLEEP:
      begin
        if (!s_q.vcc_s)
          s_d.st = NVS_OFF;
        else if (wake_in)
        begin
          s_d.st = NVS_WAKE;
          tmr_req = '{load: 1'b1, val: PU_LD};
        end
      end
      NVS_WAKE:
      begin
        if (tmr_done)
          s_d.st = NVS_READY;
      end
      default:
      begin
        s_d.st = NVS_OFF;
      end
    endcase
    s_d.dirty = wr_ok || (s_q.dirty && !clr);
    s_d.access = (s_d.st == NVS_READY) && s_d.vcc_s && s_d.pin_s;
    s_d.wr_en = s_d.access || (s_d.st == NVS_GRACE);
    s_d.pin_oe = (s_d.st inside {NVS_PWRUP, NVS_GRACE, NVS_STORE,
                                 NVS_RECALL, NVS_HIGHDRV});
    s_d.pin_o = (s_d.st == NVS_HIGHDRV);
    s_d.sleep = (s_d.st == NVS_SLEEP);
    if (s_d.st != NVS_READY)
      s_d.standby = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      s_q <= NVS_STATE_RST;
    else if (ce_in)
      s_q <= s_d;
  end

  assign store_busy_pin_n_out = s_q.pin_o;
  assign store_busy_pin_n_oe_out = s_q.pin_oe;
  assign access_en_out = s_q.access;
  assign write_en_out = s_q.wr_en;
  assign dirty_out = s_q.dirty;
  assign standby_out = s_q.standby;
  assign sleep_out = s_q.sleep;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] dwell_q;
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      dwell_q <= '0;
    else if (ce_in)
      dwell_q <= (s_d.st != s_q.st) ? '0 : dwell_q + CNT_W'(1);
  end

  property p_skip_clean;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    (s_q.st == NVS_READY && !s_q.dirty && !wr_ok)
      |=> s_q.st != NVS_GRACE;
  endproperty
  a_skip_clean: assert property (p_skip_clean)
    else $error("store started with clean array");

  property p_grace;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    $rose(s_q.st == NVS_GRACE) |-> write_en_out ##1 s_q.st == NVS_STORE;
  endproperty
  a_grace: assert property (p_grace)
    else $error("write window not one cycle");

  property p_no_access;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    (s_q.st inside {NVS_STORE, NVS_RECALL, NVS_PWRUP} || !s_q.vcc_s)
      |-> !access_en_out;
  endproperty
  a_no_access: assert property (p_no_access)
    else $error("access during busy or low supply");

  property p_store_len;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    s_q.st == NVS_STORE |-> dwell_q < ST_LD;
  endproperty
  a_store_len: assert property (p_store_len)
    else $error("store too long");

  property p_pwrup_len;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    s_q.st == NVS_PWRUP |-> dwell_q < PR_LD;
  endproperty
  a_pwrup_len: assert property (p_pwrup_len)
    else $error("power-up recall too long");

  property p_ready_after;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    $fell(s_q.st == NVS_HIGHDRV) && s_q.vcc_s
      |-> ##[1:50] s_q.st == NVS_READY;
  endproperty
  a_ready_after: assert property (p_ready_after)
    else $error("not ready after pin release");

  property p_high_drive;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    $rose(store_busy_pin_n_oe_out && store_busy_pin_n_out)
      |-> ##[1:5] !store_busy_pin_n_oe_out;
  endproperty
  a_high_drive: assert property (p_high_drive)
    else $error("pin driven high too long");

  property p_recall_len;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    s_q.st == NVS_RECALL |-> dwell_q < RC_LD;
  endproperty
  a_recall_len: assert property (p_recall_len)
    else $error("recall too long");

  property p_pin_lock;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    !s_q.pin_s |-> !access_en_out;
  endproperty
  a_pin_lock: assert property (p_pin_lock)
    else $error("access while pin held low");

  property p_dirty;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    wr_ok |=> dirty_out;
  endproperty
  a_dirty: assert property (p_dirty)
    else $error("write did not set dirty");

  property p_busy_low;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    s_q.st inside {NVS_STORE, NVS_RECALL, NVS_PWRUP}
      |-> store_busy_pin_n_oe_out && !store_busy_pin_n_out;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("pin not low while busy");

  property p_standby;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    (s_q.st == NVS_READY && s_d.st == NVS_READY && bus_stop_in)
      |=> standby_out;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not entered");

  c_pwrup: cover property (@(posedge clk_in) disable iff (!nrst_in)
    s_q.st == NVS_RELEASE ##1 s_q.st == NVS_READY);
  c_hw_store: cover property (@(posedge clk_in) disable iff (!nrst_in)
    !s_q.pin_s && s_q.st == NVS_GRACE);
  c_recall: cover property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(s_q.st == NVS_RECALL));
  c_wake: cover property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(s_q.st == NVS_WAKE));

endmodule

// ==== nvs_far_model.sv ====
// Far-side model: an outside agent that pulls the store/busy pin low.
// Assumes the sequencer's clock; the pin has a pull-up when undriven.
`timescale 1ns/10ps
module nvs_far_model
(
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [3:0] width_in,
  input wire logic dev_out_in,
  input wire logic dev_oe_in,
  output logic pin_out
);
  logic [3:0] low_q = 4'h0;

  // store request width
  // One cycle is 100 ns, so even the shortest pulse is wide enough
  always_ff @(posedge clk_in)
    if (req_in)
      low_q <= (width_in == 4'h0) ? 4'h1 : width_in;
    else if (low_q != 4'h0)
      low_q <= low_q - 4'h1;

  // Pull-up wins only while nobody drives the pin
  assign pin_out = (low_q != 4'h0) ? 1'b0 : (dev_oe_in ? dev_out_in : 1'b1);
endmodule

// ==== nvs_seq_test.sv ====
// Self-checking bench for the store/recall sequencer.
// Assumes shortened store, recall, power-up and sleep counts of CY cycles, and 2*CY for the low-voltage power-up.
`timescale 1ns/10ps
module nvs_seq_test;
  import nvs_pkg::*;
  localparam int CY = 20;
  // High drive, release and synchroniser slack
  localparam int TAIL = 62;
  logic clk_in, nrst_in, ce_in, vcc_ok_in, req, pin;
  // write, store, recall, sleep, wake, stop, start
  logic [6:0] pls;
  logic [3:0] wid;
  logic [4:0] obs;
  logic pin_o, pin_oe, acc, wen, dirty, stby, slp, busy, lv_acc;
  int error_cnt, checks_done, hi_cnt, n;
  assign obs = {lv_acc, slp, stby, dirty, acc};

  // Low-voltage variant on the same stimulus, watched for its recall
  nvs_seq #(.LOW_VCC_VARIANT(1'b1), .STORE_CYCLES(CY), .PU_CYCLES(CY),
    .PU_LV_CYCLES(2*CY), .RECALL_CYCLES(CY), .SLEEP_CYCLES(CY)) nvs_seq_lv_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .vcc_ok_in(vcc_ok_in), .store_busy_pin_n_in(pin),
    .sram_write_in(pls[6]), .sw_store_in(pls[5]), .sw_recall_in(pls[4]),
    .sleep_cmd_in(pls[3]), .wake_in(pls[2]), .bus_stop_in(pls[1]),
    .bus_start_in(pls[0]), .store_busy_pin_n_out(),
    .store_busy_pin_n_oe_out(), .access_en_out(lv_acc),
    .write_en_out(), .dirty_out(), .standby_out(), .sleep_out());

  nvs_seq #(.STORE_CYCLES(CY), .PU_CYCLES(CY), .PU_LV_CYCLES(2*CY),
    .RECALL_CYCLES(CY), .SLEEP_CYCLES(CY)) nvs_seq_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .vcc_ok_in(vcc_ok_in), .store_busy_pin_n_in(pin),
    .sram_write_in(pls[6]), .sw_store_in(pls[5]), .sw_recall_in(pls[4]),
    .sleep_cmd_in(pls[3]), .wake_in(pls[2]), .bus_stop_in(pls[1]),
    .bus_start_in(pls[0]), .store_busy_pin_n_out(pin_o),
    .store_busy_pin_n_oe_out(pin_oe), .access_en_out(acc),
    .write_en_out(wen), .dirty_out(dirty), .standby_out(stby),
    .sleep_out(slp));

  nvs_far_model nvs_far_model_i (.clk_in(clk_in), .req_in(req),
    .width_in(wid), .dev_out_in(pin_o), .dev_oe_in(pin_oe), .pin_out(pin));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk_in);
    if (k > 0)
      #1;
  endtask

  task pulse(input int b);
    pls[b] = 1'b1;
    cyc(1);
    pls[b] = 1'b0;
  endtask

  task wait_for(input int b, input logic v, input int lim, input string s);
    int i;
    i = 0;
    while (obs[b] !== v && i < lim)
    begin
      cyc(1);
      i++;
    end
    chk(obs[b], v, s);
  endtask

  task writes();
    n = 1 + $urandom % 6;
    repeat (n)
    begin
      pulse(6);
      cyc(1 + $urandom % 2);
    end
  endtask

  task pin_req();
    busy = 1'b0;
    wid = 4'h5 + 4'($urandom % 5);
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(3);
  endtask

  task test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Pin monitor
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (pin_oe === 1'b1 && pin_o === 1'b0)
      busy = 1'b1;
    hi_cnt = (pin_oe === 1'b1 && pin_o === 1'b1) ? hi_cnt + 1 : 0;
    if (hi_cnt > 5)
      chk(1'b0, 1'b1, "pin driven high too long");
  end

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial
  begin
    #(4000 * 100);
    error_cnt++;
    $display("BAD t=%0t watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {nrst_in, vcc_ok_in, req, busy} = 4'h0;
    {pls, wid} = '0;
    ce_in = 1'b1;
    {error_cnt, checks_done, hi_cnt} = 0;
    void'($urandom(92));
    cyc(8);
    nrst_in = 1'b1;
    vcc_ok_in = 1'b1;
    cyc(3);
    chk(acc, 1'b0, "access in power-up recall");
    wait_for(0, 1'b1, 3 + CY + TAIL, "power-up recall slow");
    chk(busy, 1'b1, "no busy in power-up recall");
    chk(dirty, 1'b0, "dirty after recall");
    chk(wen, 1'b1, "writes shut when ready");
    chk(lv_acc, 1'b0, "low-voltage recall too short");
    wait_for(4, 1'b1, CY + 4, "low-voltage recall slow");
    $display("test powerup done");
    pulse(1);
    chk(stby, 1'b1, "standby not entered");
    pulse(0);
    chk(stby, 1'b0, "standby not left");
    $display("test standby done");
    writes();
    chk(dirty, 1'b1, "write left clean");
    busy = 1'b0;
    pulse(4);
    cyc(1);
    chk(acc, 1'b0, "access in sw recall");
    wait_for(0, 1'b1, CY + TAIL, "sw recall slow");
    chk(dirty, 1'b0, "recall left dirty");
    chk(busy, 1'b1, "no busy in sw recall");
    $display("test recall done");
    pin_req();
    chk(acc, 1'b0, "access while pin low");
    wait_for(0, 1'b1, 50 + 12, "slow after pin high");
    chk(busy, 1'b0, "clean pin store ran");
    writes();
    pin_req();
    chk(acc, 1'b0, "access in pin store");
    wait_for(0, 1'b1, 12 + CY + TAIL, "pin store slow");
    chk(busy, 1'b1, "dirty pin store skipped");
    chk(dirty, 1'b0, "store left dirty");
    $display("test pin store done");
    busy = 1'b0;
    pulse(5);
    cyc(1);
    chk(acc, 1'b0, "access in sw store");
    ce_in = 1'b0;
    cyc(CY + TAIL);
    chk(acc, 1'b0, "store ran while frozen");
    ce_in = 1'b1;
    wait_for(0, 1'b1, CY + TAIL, "sw store slow");
    chk(busy, 1'b1, "clean sw store skipped");
    $display("test sw store done");
    cyc($urandom % 4);
    pulse(3);
    wait_for(3, 1'b1, CY + 4, "sleep slow");
    chk(acc, 1'b0, "access while asleep");
    pulse(2);
    wait_for(0, 1'b1, CY + TAIL, "wake slow");
    chk(slp, 1'b0, "sleep after wake");
    $display("test sleep done");
    writes();
    busy = 1'b0;
    vcc_ok_in = 1'b0;
    cyc(3);
    chk(acc, 1'b0, "access below trip");
    chk(wen, 1'b1, "no write window on power loss");
    pulse(6);
    chk(wen, 1'b0, "writes open in store");
    cyc(CY + 1);
    chk(busy, 1'b1, "dirty power-loss store skipped");
    chk(dirty, 1'b0, "power-loss store left dirty");
    pulse(5);
    cyc(2);
    chk(acc, 1'b0, "command taken while off");
    vcc_ok_in = 1'b1;
    wait_for(0, 1'b1, 3 + CY + TAIL, "second power-up slow");
    chk(dirty, 1'b0, "dirty after power-up");
    busy = 1'b0;
    vcc_ok_in = 1'b0;
    cyc(CY + 8);
    chk(busy, 1'b0, "clean power-loss store ran");
    $display("test power loss done");
    test_done();
  end
endmodule
